// file: rtl/serial_host_port_datapath.sv
// Serial host port datapath: shift register, transmit holding, receive FIFO, address match
`timescale 1ns/1ps
module serial_host_port_datapath (
   input wire logic clk,
   input wire logic rstn,
   // Software reset, individual reset and stop mode clear data paths
   input wire logic soft_reset,
   input wire logic host_enable,
   input wire logic stop_mode,
   // Mode controls
   input wire logic master_select_bit,
   input wire logic i2c_mode,
   input wire logic clock_freeze_bit,
   input wire logic prescale_bypass,
   input wire logic [7:0] divider_modulus,
   input wire logic [1:0] word_size,
   input wire logic transmit_irq_enable,
   input wire logic receive_irq_enable,
   input wire logic bus_error,
   // Core register port
   input wire logic reg_write,
   input wire logic reg_read,
   input wire logic [1:0] reg_select,
   input wire logic [23:0] reg_wdata,
   output logic [23:0] reg_rdata,
   // Serial side: external clock edge and data in slave mode
   input wire logic ext_shift_strobe,
   input wire logic serial_in,
   output logic serial_out,
   output logic shift_enable,
   input wire logic word_start,
   input wire logic addr_byte_valid,
   input wire logic addr_pin_bit0,
   input wire logic addr_pin_bit2,
   output logic addr_match,
   output logic baud_tick,
   // Status and interrupt
   output logic transmit_empty_flag,
   output logic receive_not_empty_flag,
   output logic receive_full_flag,
   output logic receive_overrun_flag,
   output logic transmit_underrun_flag,
   output logic irq_request,
   output logic [7:0] irq_vector
);
   logic clear_path;
   logic gen_active;
   logic [2:0] prescale_cnt;
   logic [7:0] divide_cnt;
   logic prescale_tick;
   logic shift_tick;
   logic [23:0] io_shift_register;
   logic [4:0] bits_left;
   logic [4:0] word_bits;
   logic [23:0] transmit_holding;
   logic [23:0] fifo_mem [0:9];
   logic [3:0] wr_ptr;
   logic [3:0] rd_ptr;
   logic [3:0] fifo_count;
   logic word_done;
   logic fifo_push;
   logic fifo_pop;
   logic [23:0] rx_word;
   logic [3:0] stored_addr_upper;
   logic stored_addr_bit1;
   logic [6:0] full_addr;
   logic [23:0] next_rdata;

   assign clear_path = soft_reset | stop_mode | ~host_enable;

   assign gen_active = master_select_bit | (i2c_mode & clock_freeze_bit);

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         prescale_cnt <= 3'h0;
      end else if (!gen_active) begin
         prescale_cnt <= 3'h0;
      end else if (prescale_cnt == serial_host_port_pkg::PRESCALE_MAX) begin
         prescale_cnt <= 3'h0;
      end else begin
         prescale_cnt <= prescale_cnt + 3'h1;
      end
   end
   assign prescale_tick = prescale_bypass | (prescale_cnt == serial_host_port_pkg::PRESCALE_MAX);

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         divide_cnt <= 8'h00;
         baud_tick <= 1'b0;
      end else if (!gen_active) begin
         divide_cnt <= 8'h00;
         baud_tick <= 1'b0;
      end else if (prescale_tick) begin
         baud_tick <= (divide_cnt == divider_modulus);
         divide_cnt <= (divide_cnt == divider_modulus) ? 8'h00 : divide_cnt + 8'h01;
      end else begin
         baud_tick <= 1'b0;
      end
   end

   assign shift_tick = master_select_bit ? baud_tick : ext_shift_strobe;

   always_comb begin
      unique case (word_size)
         serial_host_port_pkg::WORD_8: word_bits = 5'd8;
         serial_host_port_pkg::WORD_16: word_bits = 5'd16;
         default: word_bits = 5'd24;
      endcase
   end

   assign shift_enable = (bits_left != 5'd0);
   assign word_done = shift_tick & (bits_left == 5'd1);

   // load aligned to top, so only top bytes go out
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         io_shift_register <= 24'h000000;
         bits_left <= 5'd0;
      end else if (clear_path) begin
         io_shift_register <= 24'h000000;
         bits_left <= 5'd0;
      end else if (word_start && bits_left == 5'd0) begin
         io_shift_register <= transmit_holding;
         bits_left <= word_bits;
      end else if (shift_tick && bits_left != 5'd0) begin
         // only active upper bytes shift
         // Keeping the received word at the top lets address match read one place
         unique case (word_size)
            serial_host_port_pkg::WORD_8: begin
               io_shift_register[23:16] <= {io_shift_register[22:16], serial_in};
            end
            serial_host_port_pkg::WORD_16: begin
               io_shift_register[23:8] <= {io_shift_register[22:8], serial_in};
            end
            default: begin
               io_shift_register <= {io_shift_register[22:0], serial_in};
            end
         endcase
         bits_left <= bits_left - 5'd1;
      end
   end
   assign serial_out = io_shift_register[23];

   // stop and resets empty the holding
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         transmit_empty_flag <= 1'b1;
         transmit_holding <= 24'h000000;
      end else if (clear_path) begin
         transmit_empty_flag <= 1'b1;
         transmit_holding <= 24'h000000;
      end else if (reg_write && reg_select == serial_host_port_pkg::REG_TRANSMIT_HOLDING) begin
         transmit_empty_flag <= 1'b0;
         transmit_holding <= reg_wdata;
      end else if (word_start && bits_left == 5'd0) begin
         transmit_empty_flag <= 1'b1;
      end
   end

   // underrun on start with empty holding
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         transmit_underrun_flag <= 1'b0;
      end else if (clear_path) begin
         transmit_underrun_flag <= 1'b0;
      end else if (word_start && bits_left == 5'd0 && transmit_empty_flag) begin
         transmit_underrun_flag <= 1'b1;
      end
   end

   always_comb begin
      unique case (word_size)
         serial_host_port_pkg::WORD_8: rx_word = {io_shift_register[22:16], serial_in, 16'h0000};
         serial_host_port_pkg::WORD_16: rx_word = {io_shift_register[22:8], serial_in, 8'h00};
         default: rx_word = {io_shift_register[22:0], serial_in};
      endcase
   end

   assign fifo_push = word_done & (fifo_count != 4'd10);
   assign fifo_pop = reg_read & (reg_select == serial_host_port_pkg::REG_RECEIVE_FIFO_PORT) & (fifo_count != 4'd0);

   always_ff @(posedge clk) begin
      if (fifo_push) begin
         fifo_mem[wr_ptr] <= rx_word;
      end
   end

   // stop and resets empty the FIFO
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         wr_ptr <= 4'd0;
         rd_ptr <= 4'd0;
         fifo_count <= 4'd0;
      end else if (clear_path) begin
         wr_ptr <= 4'd0;
         rd_ptr <= 4'd0;
         fifo_count <= 4'd0;
      end else begin
         if (fifo_push) begin
            wr_ptr <= (wr_ptr == 4'd9) ? 4'd0 : wr_ptr + 4'd1;
         end
         if (fifo_pop) begin
            rd_ptr <= (rd_ptr == 4'd9) ? 4'd0 : rd_ptr + 4'd1;
         end
         fifo_count <= fifo_count + {3'h0, fifo_push} - {3'h0, fifo_pop};
      end
   end
   assign receive_not_empty_flag = (fifo_count != 4'd0);
   assign receive_full_flag = (fifo_count == 4'd10);

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         receive_overrun_flag <= 1'b0;
      end else if (clear_path) begin
         receive_overrun_flag <= 1'b0;
      end else if (word_done && fifo_count == 4'd10) begin
         receive_overrun_flag <= 1'b1;
      end
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         stored_addr_upper <= serial_host_port_pkg::ADDR_UPPER_RESET;
         stored_addr_bit1 <= serial_host_port_pkg::ADDR_BIT1_RESET;
      end else if (soft_reset) begin
         stored_addr_upper <= serial_host_port_pkg::ADDR_UPPER_RESET;
         stored_addr_bit1 <= serial_host_port_pkg::ADDR_BIT1_RESET;
      end else if (reg_write && reg_select == serial_host_port_pkg::REG_SLAVE_ADDRESS_SELECT) begin
         stored_addr_upper <= reg_wdata[serial_host_port_pkg::ADDR_UPPER_MSB:serial_host_port_pkg::ADDR_UPPER_LSB];
         stored_addr_bit1 <= reg_wdata[serial_host_port_pkg::ADDR_BIT1_POS];
      end
   end

   // assemble address from register and pins
   assign full_addr = {stored_addr_upper, addr_pin_bit2, stored_addr_bit1, addr_pin_bit0};

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         addr_match <= 1'b0;
      end else if (!i2c_mode || master_select_bit || clear_path) begin
         addr_match <= 1'b0;
      end else if (addr_byte_valid) begin
         addr_match <= (io_shift_register[23:17] == full_addr) || (io_shift_register[23:16] == 8'h00);
      end
   end

   always_comb begin
      next_rdata = 24'h000000;
      if (reg_select == serial_host_port_pkg::REG_RECEIVE_FIFO_PORT && fifo_count != 4'd0) begin
         next_rdata = fifo_mem[rd_ptr];
      end else if (reg_select == serial_host_port_pkg::REG_SLAVE_ADDRESS_SELECT) begin
         next_rdata = {stored_addr_upper, 1'b0, stored_addr_bit1, 18'h00000};
      end
   end

   // Read data registered; the FIFO word presented is the one popped this cycle
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         reg_rdata <= 24'h000000;
      end else if (reg_read) begin
         reg_rdata <= next_rdata;
      end
   end

   always_comb begin
      irq_request = 1'b1;
      if (bus_error) begin
         irq_vector = serial_host_port_pkg::VEC_BUS_ERROR;
      end else if (receive_overrun_flag) begin
         irq_vector = serial_host_port_pkg::VEC_RX_OVERRUN;
      end else if (transmit_underrun_flag) begin
         irq_vector = serial_host_port_pkg::VEC_TX_UNDERRUN;
      end else if (receive_full_flag && receive_irq_enable) begin
         irq_vector = serial_host_port_pkg::VEC_RX_FULL;
      end else if (transmit_empty_flag && transmit_irq_enable && host_enable) begin
         irq_vector = serial_host_port_pkg::VEC_TX_DATA;
      end else if (receive_not_empty_flag && receive_irq_enable) begin
         irq_vector = serial_host_port_pkg::VEC_RX_NOT_EMPTY;
      end else begin
         irq_request = 1'b0;
         irq_vector = 8'h00;
      end
   end
endmodule

// file: rtl/serial_host_port_pkg.sv
// Constants shared by the serial host port datapath
package serial_host_port_pkg;
   // Register select codes on the core-side register port
   localparam logic [1:0] REG_TRANSMIT_HOLDING = 2'h0;
   localparam logic [1:0] REG_RECEIVE_FIFO_PORT = 2'h1;
   localparam logic [1:0] REG_SLAVE_ADDRESS_SELECT = 2'h2;
   // Slave address register fields
   localparam int ADDR_UPPER_MSB = 23;
   localparam int ADDR_UPPER_LSB = 20;
   localparam int ADDR_BIT1_POS = 18;
   localparam logic [3:0] ADDR_UPPER_RESET = 4'hB;
   localparam logic ADDR_BIT1_RESET = 1'b0;
   // Word size codes
   localparam logic [1:0] WORD_8 = 2'h0;
   localparam logic [1:0] WORD_16 = 2'h1;
   localparam logic [1:0] WORD_24 = 2'h2;
   localparam int DATA_W = 24;
   localparam int FIFO_DEPTH = 10;
   // Interrupt vector offsets from the vector base
   localparam logic [7:0] VEC_TX_DATA = 8'h40;
   localparam logic [7:0] VEC_TX_UNDERRUN = 8'h42;
   localparam logic [7:0] VEC_RX_NOT_EMPTY = 8'h44;
   localparam logic [7:0] VEC_RX_FULL = 8'h48;
   localparam logic [7:0] VEC_RX_OVERRUN = 8'h4A;
   localparam logic [7:0] VEC_BUS_ERROR = 8'h4C;
   // Prescaler terminal count when not bypassed (divide by 8)
   localparam logic [2:0] PRESCALE_MAX = 3'h7;
endpackage

// file: tb/serial_host_port_datapath_asserts.sv
// Assertion checker for the serial host port datapath
`timescale 1ns/1ps
module serial_host_port_datapath_asserts (
   input wire logic clk,
   input wire logic rstn,
   input wire logic soft_reset,
   input wire logic host_enable,
   input wire logic stop_mode,
   input wire logic master_select_bit,
   input wire logic i2c_mode,
   input wire logic clock_freeze_bit,
   input wire logic bus_error,
   input wire logic reg_write,
   input wire logic reg_read,
   input wire logic [1:0] reg_select,
   input wire logic [23:0] reg_rdata,
   input wire logic word_start,
   input wire logic shift_enable,
   input wire logic baud_tick,
   input wire logic transmit_empty_flag,
   input wire logic receive_not_empty_flag,
   input wire logic receive_overrun_flag,
   input wire logic transmit_underrun_flag,
   input wire logic irq_request,
   input wire logic [7:0] irq_vector
);
   default clocking dc @(posedge clk); endclocking
   default disable iff (!rstn);
   logic clr;
   logic idle;
   assign clr = soft_reset | stop_mode | !host_enable;
   assign idle = !master_select_bit && !(i2c_mode && clock_freeze_bit);
   property p_vec_err; bus_error |-> irq_request && irq_vector == 8'h4C; endproperty
   a_vec_err: assert property (p_vec_err) else $error("bus error vector wrong");
   property p_vec_ovr; !bus_error && receive_overrun_flag |-> irq_vector == 8'h4A; endproperty
   a_vec_ovr: assert property (p_vec_ovr) else $error("overrun vector wrong");
   property p_vec_und; !bus_error && !receive_overrun_flag && transmit_underrun_flag |-> irq_vector == 8'h42;
   endproperty
   a_vec_und: assert property (p_vec_und) else $error("underrun vector wrong");
   property p_wr_clr; reg_write && reg_select == 2'h0 && !clr && !word_start |=> !transmit_empty_flag; endproperty
   a_wr_clr: assert property (p_wr_clr) else $error("holding write kept empty flag");
   property p_load; word_start && !shift_enable && !clr && !reg_write |=> transmit_empty_flag && shift_enable;
   endproperty
   a_load: assert property (p_load) else $error("word load wrong");
   property p_und; word_start && !shift_enable && transmit_empty_flag && !clr |=> transmit_underrun_flag;
   endproperty
   a_und: assert property (p_und) else $error("underrun not flagged");
   property p_clr; clr && !reg_write |=> transmit_empty_flag && !receive_not_empty_flag && !receive_overrun_flag;
   endproperty
   a_clr: assert property (p_clr) else $error("data path not cleared");
   // Two cycles of slave mode without I2C clock freeze so the registered tick has drained
   property p_gen_off; idle [*2] |-> !baud_tick; endproperty
   a_gen_off: assert property (p_gen_off) else $error("generator ran in slave mode");
   property p_addr_rsv; reg_read && reg_select == 2'h2 |=> reg_rdata[17:0] == 18'h00000 && !reg_rdata[19];
   endproperty
   a_addr_rsv: assert property (p_addr_rsv) else $error("unused address bits set");
   c_ovr: cover property (receive_overrun_flag);
   c_und: cover property (transmit_underrun_flag);
   c_tick: cover property (baud_tick);
endmodule
bind serial_host_port_datapath serial_host_port_datapath_asserts chk_u (.*);

// file: tb/serial_host_port_datapath_tb_top.sv
// Self-checking testbench for the serial host port datapath
`timescale 1ns/1ps
`define CHK(nm, e, g) begin check_count++; if ((g) !== (e)) begin err_count++; \
   $display("BAD %s exp %h got %h", nm, e, g); end end
module serial_host_port_datapath_tb_top;
   logic clk, rstn, soft_reset, host_enable, stop_mode, master_select_bit, i2c_mode, clock_freeze_bit;
   logic prescale_bypass, transmit_irq_enable, receive_irq_enable, bus_error, reg_write, reg_read;
   logic ext_shift_strobe, serial_in, serial_out, shift_enable, word_start, addr_byte_valid, addr_match;
   logic addr_pin_bit0, addr_pin_bit2, baud_tick, transmit_empty_flag, receive_not_empty_flag;
   logic receive_full_flag, receive_overrun_flag, transmit_underrun_flag, irq_request;
   logic [7:0] divider_modulus, irq_vector;
   logic [1:0] word_size, reg_select;
   logic [23:0] reg_wdata, reg_rdata, rd, got;
   logic [3:0] gcfg [4] = '{4'b0000, 4'b1001, 4'b0110, 4'b1000};
   int gexp [4] = '{0, 10, 5, 5};
   logic [2:0] ccfg [3] = '{3'b110, 3'b000, 3'b011};
   logic [7:0] mbyte [5] = '{8'hBA, 8'h00, 8'hB8, 8'hBA, 8'hB8};
   int err_count, check_count, n, nb;
   serial_host_port_datapath dut_u (.*);
   serial_host_port_partner partner_u (.*);
   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end
   task automatic end_sim;
      $display("checks %0d errors %0d", check_count, err_count);
      if (err_count == 0 && check_count > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask
   task automatic acc(input logic wr, input logic [1:0] s, input logic [23:0] d);
      @(negedge clk);
      reg_select = s;
      reg_wdata = d;
      reg_write = wr;
      reg_read = !wr;
      @(negedge clk);
      reg_write = 1'b0;
      reg_read = 1'b0;
      rd = reg_rdata;
   endtask
   task automatic word(input logic [23:0] din, input int nbits);
      for (int i = 0; i < 8 && shift_enable !== 1'b0; i++)
         @(negedge clk);
      if (shift_enable !== 1'b0) begin
         err_count++;
         end_sim();
      end
      word_start = 1'b1;
      @(negedge clk);
      word_start = 1'b0;
      `CHK("tx_load", 1'b1, transmit_empty_flag)
      partner_u.xfer(din, nbits, got);
   endtask
   initial begin
      {rstn, soft_reset, stop_mode, master_select_bit, i2c_mode, clock_freeze_bit, prescale_bypass} = '0;
      {divider_modulus, word_size, transmit_irq_enable, receive_irq_enable, bus_error} = '0;
      {reg_write, reg_read, reg_select, reg_wdata, word_start, addr_byte_valid} = '0;
      {addr_pin_bit0, addr_pin_bit2, host_enable} = 3'b111;
      err_count = 0;
      check_count = 0;
      repeat (3) @(negedge clk);
      rstn = 1'b1;
      acc(1'b0, serial_host_port_pkg::REG_SLAVE_ADDRESS_SELECT, 24'h000000);
      `CHK("addr_rst", 24'hB00000, rd)
      `CHK("irq_idle", 1'b0, irq_request)
      acc(1'b1, serial_host_port_pkg::REG_SLAVE_ADDRESS_SELECT, 24'hFFFFFF);
      acc(1'b0, serial_host_port_pkg::REG_SLAVE_ADDRESS_SELECT, 24'h000000);
      `CHK("addr_rsv", 24'hF40000, rd)
      transmit_irq_enable = 1'b1;
      #1;
      `CHK("vec_tx", 8'h40, irq_vector)
      `CHK("irq_req", 1'b1, irq_request)
      transmit_irq_enable = 1'b0;
      receive_irq_enable = 1'b1;
      // Settling cycles let the divider leave its old phase
      for (int k = 0; k < 4; k++) begin
         {master_select_bit, i2c_mode, clock_freeze_bit, prescale_bypass} = gcfg[k];
         divider_modulus = (k == 1) ? 8'h03 : 8'h00;
         n = 0;
         repeat (16) @(negedge clk);
         repeat (40) begin
            @(negedge clk);
            n += (baud_tick === 1'b1);
         end
         `CHK("ticks", gexp[k], n)
      end
      {master_select_bit, i2c_mode, clock_freeze_bit} = 3'b000;
      for (int ws = 0; ws < 3; ws++) begin
         word_size = ws[1:0];
         nb = 8 * (ws + 1);
         acc(1'b1, serial_host_port_pkg::REG_TRANSMIT_HOLDING, 24'hA5C37E);
         `CHK("tx_full", 1'b0, transmit_empty_flag)
         word(24'h8C1E5B >> (24 - nb), nb);
         `CHK("tx_bits", 24'hA5C37E >> (24 - nb), got)
         `CHK("vec_rx", 8'h44, irq_vector)
         acc(1'b0, serial_host_port_pkg::REG_RECEIVE_FIFO_PORT, 24'h000000);
         `CHK("rx_word", 24'h8C1E5B & ~(24'hFFFFFF >> nb), rd)
      end
      `CHK("tx_und0", 1'b0, transmit_underrun_flag)
      word_size = serial_host_port_pkg::WORD_8;
      for (int i = 0; i < 11; i++) begin
         word(24'(i + 1), 8);
         if (i < 10)
            `CHK("rx_full", 1'(i == 9), receive_full_flag)
      end
      `CHK("rx_ovr", 1'b1, receive_overrun_flag)
      `CHK("tx_und", 1'b1, transmit_underrun_flag)
      `CHK("vec_ovr", 8'h4A, irq_vector)
      bus_error = 1'b1;
      #1;
      `CHK("vec_err", 8'h4C, irq_vector)
      bus_error = 1'b0;
      for (int i = 0; i < 11; i++) begin
         acc(1'b0, serial_host_port_pkg::REG_RECEIVE_FIFO_PORT, 24'h000000);
         `CHK("rx_fifo", (i < 10) ? 24'(i + 1) << 16 : 24'h000000, rd)
      end
      `CHK("rx_ne", 1'b0, receive_not_empty_flag)
      for (int k = 0; k < 3; k++) begin
         word(24'h0000C3, 8);
         acc(1'b1, serial_host_port_pkg::REG_TRANSMIT_HOLDING, 24'h123456);
         {stop_mode, host_enable, soft_reset} = ccfg[k];
         @(negedge clk);
         {stop_mode, host_enable, soft_reset} = 3'b010;
         `CHK("clr_tx", 1'b1, transmit_empty_flag)
         `CHK("clr_rx", 1'b0, receive_not_empty_flag)
      end
      acc(1'b0, serial_host_port_pkg::REG_SLAVE_ADDRESS_SELECT, 24'h000000);
      `CHK("addr_sw", 24'hB00000, rd)
      for (int k = 0; k < 5; k++) begin
         i2c_mode = 1'(5'b10111 >> k);
         addr_pin_bit0 = 1'(5'b01111 >> k);
         word({16'h0000, mbyte[k]}, 8);
         addr_byte_valid = 1'b1;
         @(negedge clk);
         addr_byte_valid = 1'b0;
         @(negedge clk);
         `CHK("addr_hit", 1'(5'b10011 >> k), addr_match)
      end
      end_sim();
   end
endmodule

// file: tb/serial_host_port_partner.sv
// Far-side serial master model: bit strobes and data
`timescale 1ns/1ps
module serial_host_port_partner (
   input wire logic clk,
   input wire logic serial_out,
   output logic serial_in,
   output logic ext_shift_strobe
);
   initial begin
      serial_in = 1'b0;
      ext_shift_strobe = 1'b0;
   end
   task automatic xfer(input logic [23:0] din, input int n, output logic [23:0] dout);
      dout = 24'h000000;
      for (int i = n - 1; i >= 0; i--) begin
         @(negedge clk);
         serial_in = din[i];
         ext_shift_strobe = 1'b1;
         dout = {dout[22:0], serial_out};
         @(negedge clk);
         ext_shift_strobe = 1'b0;
      end
      // Released line must not look like held data
      serial_in = ~din[0];
   endtask
endmodule
